// ===== rtl/fpm_menu_ctrl.sv
// Behaviour
// - saved settings: alternate two messages, then main
// - no saved settings: hold setup prompt
// - back at prompt keeps factory, goes main
// - choose at prompt opens curve type item
// - choose adopts shown curve, enters elements
// - view arrows move function, edit arrows value
// - save commits edits, user set becomes active
// - view arrows scroll current menu entries
// - choose opens submenu of blinking item
// - back climbs one level toward main
// - test menu edit arrows change test level
// - save in test menu launches test when test level is not zero
// - battery button lights green when battery good
// - blink middle text when item selectable
// - meter submenu shows one to 22 screens
// - hide ground or neutral screens by model
// - reset clears cause LEDs, trip LED, data
// - view down shows timestamp, then current; logged
// - trip current is sixteen bits, 65535 max
// - alarm re-asserts after reset while present
// - back hides alarm message, LED stays lit
// - reset on meter screen resets its values
// - trip LED pulses every four seconds
`timescale 1ns/1ns
`default_nettype none
module fpm_menu_ctrl
  import fpm_pkg::*;
#(
  parameter int         P_DEBOUNCE_CYC   = DEBOUNCE_CYC,
  parameter int         P_TRIP_FLASH_CYC = TRIP_FLASH_CYC,
  parameter int         P_TRIP_ON_CYC    = TRIP_FLASH_ON_CYC,
  parameter int         P_BLINK_CYC      = BLINK_CYC,
  parameter logic [4:0] P_METER_MAX      = METER_MAX
)
(
  // clock and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  // raw pushbuttons, high while pressed
  input  wire logic [8:0]    i_buttons,
  // device status
  input  wire logic          i_settings_saved,
  input  wire logic          i_four_element,
  input  wire logic          i_alarm_active,
  input  wire logic          i_battery_ok,
  input  wire logic [4:0]    i_meter_screens,
  // trip capture
  input  wire logic          i_trip_event,
  input  wire logic [3:0]    i_trip_cause,
  input  wire logic [15:0]   i_trip_current,
  input  wire logic [31:0]   i_trip_timestamp,
  // display
  output fpm_state_type      o_screen,
  output logic [4:0]         o_item,
  output logic               o_middle_blink,
  output logic [1:0]         o_curve_type,
  output logic [2:0]         o_func_index,
  output logic [7:0]         o_edit_value,
  output logic [7:0]         o_active_value,
  output logic               o_user_active,
  output logic               o_save_pulse,
  // self test
  output logic [3:0]         o_test_level,
  output logic               o_test_prompt,
  output logic               o_test_start,
  // meter
  output logic               o_meter_reset,
  output logic [4:0]         o_meter_screen,
  // trip data and log
  output logic               o_trip_data_valid,
  output logic [15:0]        o_trip_current,
  output logic [31:0]        o_trip_timestamp,
  output logic               o_log_write,
  // indicators
  output logic               o_trip_led,
  output logic [3:0]         o_cause_led,
  output logic               o_alarm_led,
  output logic               o_alarm_msg,
  output logic               o_battery_led
);
  if (P_METER_MAX < 5'h01 || P_METER_MAX > METER_MAX)
  begin : g_bad_meter_max
    $error("fpm_menu_ctrl: bad meter max");
  end

  ////////////////////////////////////////////////////////////////////////////////
  fpm_btn_if #(.N(BTN_CNT)) btn_bus ();

  fpm_debounce #(.N(BTN_CNT), .CNT(P_DEBOUNCE_CYC)) u_debounce (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_raw     (i_buttons),
    .btn       (btn_bus.src)
  );

  logic blink_tick;
  logic blink_on;
  logic flash_on;

  fpm_ticker #(.PERIOD(P_BLINK_CYC), .ON(P_BLINK_CYC / 2)) u_blink (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .o_tick    (blink_tick),
    .o_on      (blink_on)
  );

  // short pulse per period keeps the battery load low after a trip
  fpm_ticker #(.PERIOD(P_TRIP_FLASH_CYC), .ON(P_TRIP_ON_CYC)) u_flash (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .o_tick    (),
    .o_on      (flash_on)
  );

  ////////////////////////////////////////////////////////////////////////////////
  fpm_state_type state_q, state_d;
  logic [4:0]    idx_q, idx_d;
  logic [1:0]    curve_q, curve_d;
  logic [3:0]    alt_q, alt_d;
  logic [3:0]    lvl_q, lvl_d;
  logic [7:0]    pend_q [FUNC_CNT];
  logic [7:0]    act_q  [FUNC_CNT];
  logic          user_q;
  logic          trip_q;
  logic [3:0]    cause_q;
  logic          msg_q;
  logic          dismiss_q;

  wire p_vu    = btn_bus.press[BTN_VIEW_UP];
  wire p_vd    = btn_bus.press[BTN_VIEW_DOWN];
  wire p_choose = btn_bus.press[BTN_CHOOSE];
  wire p_reset = btn_bus.press[BTN_RESET];
  wire p_eu    = btn_bus.press[BTN_EDIT_UP];
  wire p_ed    = btn_bus.press[BTN_EDIT_DOWN];
  wire p_save  = btn_bus.press[BTN_SAVE];
  // a back press that dismisses an alarm message does not also climb a level
  wire p_back_alarm = btn_bus.press[BTN_BACK] && msg_q;
  wire p_back  = btn_bus.press[BTN_BACK] && !msg_q;

  wire [4:0] func_vis  = {2'b00, i_four_element ? FUNC_VIS_4EL : FUNC_VIS_3EL};
  wire [2:0] func_sel  = fpm_func_map(idx_q[2:0], i_four_element);
  wire [4:0] meter_cnt = (i_meter_screens == 5'h00) ? 5'h01 :
                         (i_meter_screens > P_METER_MAX) ? P_METER_MAX : i_meter_screens;
  wire [7:0] cur_val   = pend_q[func_sel];

  wire in_edit   = state_q == ST_EDIT;
  wire edit_up   = in_edit && p_eu && cur_val != VAL_MAX;
  wire edit_dn   = in_edit && p_ed && cur_val != 8'h00;
  wire commit    = p_save && (state_q == ST_EDIT || state_q == ST_CURVE);
  wire test_go   = state_q == ST_TEST && p_save && lvl_q != 4'h0;
  wire meter_rst = state_q == ST_METER && p_reset;
  wire trip_clr  = p_reset && !i_trip_event;
  wire selectable = state_q == ST_MAIN || state_q == ST_CURVE || state_q == ST_PROMPT;
  wire vu_next   = p_vu && !p_vd;
  wire vd_next   = p_vd && !p_vu;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    idx_d   = idx_q;
    curve_d = curve_q;
    alt_d   = alt_q;
    lvl_d   = lvl_q;
    case (state_q)
      ST_BOOT:
      begin
        state_d = i_settings_saved ? ST_PWR_A : ST_PROMPT;
      end
      ST_PWR_A, ST_PWR_B:
      begin
        if (blink_tick)
        begin
          alt_d   = alt_q + 4'h1;
          state_d = (state_q == ST_PWR_A) ? ST_PWR_B : ST_PWR_A;
          if (alt_q == PWR_ALT_CNT - 4'h1)
          begin
            state_d = ST_MAIN;
          end
        end
      end
      ST_PROMPT:
      begin
        if (p_back || i_alarm_active)
        begin
          state_d = ST_MAIN;
        end
        else if (p_choose)
        begin
          state_d = ST_CURVE;
          idx_d   = {3'b000, curve_q};
        end
      end
      ST_MAIN:
      begin
        if (vu_next) idx_d = fpm_wrap_inc(idx_q, MAIN_ITEMS);
        if (vd_next) idx_d = fpm_wrap_dec(idx_q, MAIN_ITEMS);
        if (p_choose)
        begin
          idx_d = 5'h00;
          case (idx_q)
            MAIN_METER:   state_d = ST_METER;
            MAIN_PROGRAM: state_d = ST_CURVE;
            MAIN_TEST:    state_d = ST_TEST;
            default:      state_d = ST_MAIN;
          endcase
          if (idx_q == MAIN_PROGRAM) idx_d = {3'b000, curve_q};
        end
      end
      ST_CURVE:
      begin
        if (vu_next) idx_d = fpm_wrap_inc(idx_q, CURVE_TYPES);
        if (vd_next) idx_d = fpm_wrap_dec(idx_q, CURVE_TYPES);
        if (p_choose)
        begin
          curve_d = idx_q[1:0];
          state_d = ST_EDIT;
          idx_d   = 5'h00;
        end
        else if (p_back)
        begin
          state_d = ST_MAIN;
          idx_d   = MAIN_PROGRAM;
        end
      end
      ST_EDIT:
      begin
        if (vu_next) idx_d = fpm_wrap_inc(idx_q, func_vis);
        if (vd_next) idx_d = fpm_wrap_dec(idx_q, func_vis);
        if (p_back)
        begin
          state_d = ST_CURVE;
          idx_d   = {3'b000, curve_q};
        end
      end
      ST_TEST:
      begin
        if (p_eu && !p_ed && lvl_q != TEST_LVL_MAX) lvl_d = lvl_q + 4'h1;
        if (p_ed && !p_eu && lvl_q != 4'h0) lvl_d = lvl_q - 4'h1;
        if (p_back)
        begin
          state_d = ST_MAIN;
          idx_d   = MAIN_TEST;
        end
      end
      ST_METER:
      begin
        if (vu_next) idx_d = fpm_wrap_inc(idx_q, meter_cnt);
        if (vd_next) idx_d = fpm_wrap_dec(idx_q, meter_cnt);
        if (p_back)
        begin
          state_d = ST_MAIN;
          idx_d   = MAIN_METER;
        end
      end
      ST_TRIP:
      begin
        if (vd_next && idx_q < TRIP_PAGES - 5'h01) idx_d = idx_q + 5'h01;
        if (vu_next && idx_q != 5'h00) idx_d = idx_q - 5'h01;
        if (trip_clr)
        begin
          state_d = ST_MAIN;
          idx_d   = 5'h00;
        end
      end
      default:
      begin
        state_d = ST_BOOT;
      end
    endcase
    // a trip overrides every screen, the power-up prompt included
    if (i_trip_event)
    begin
      state_d = ST_TRIP;
      idx_d   = 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= ST_BOOT;
      idx_q   <= 5'h00;
      curve_q <= FACTORY_CURVE;
      alt_q   <= 4'h0;
      lvl_q   <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= idx_d;
      curve_q <= curve_d;
      alt_q   <= alt_d;
      lvl_q   <= lvl_d;
    end
  end

  // pending edits only reach the active set on save
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < FUNC_CNT; i++)
      begin
        pend_q[i] <= FACTORY_VAL;
        act_q[i]  <= FACTORY_VAL;
      end
      user_q <= 1'b0;
    end
    else
    begin
      if (edit_up) pend_q[func_sel] <= cur_val + 8'h01;
      if (edit_dn) pend_q[func_sel] <= cur_val - 8'h01;
      if (commit)
      begin
        for (int i = 0; i < FUNC_CNT; i++) act_q[i] <= pend_q[i];
      end
      // the strap is caught on the first clocked cycle, never by the reset itself
      if (state_q == ST_BOOT) user_q <= i_settings_saved;
      else if (commit) user_q <= 1'b1;
    end
  end

  // trip capture; a new trip wins over a reset press in the same cycle
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      trip_q            <= 1'b0;
      cause_q           <= 4'h0;
      o_trip_data_valid <= 1'b0;
      o_trip_current    <= 16'h0000;
      o_trip_timestamp  <= 32'h0000_0000;
      o_log_write       <= 1'b0;
    end
    else
    begin
      o_log_write <= i_trip_event;
      if (i_trip_event)
      begin
        trip_q            <= 1'b1;
        cause_q           <= cause_q | i_trip_cause;
        o_trip_data_valid <= 1'b1;
        o_trip_current    <= i_trip_current;
        o_trip_timestamp  <= i_trip_timestamp;
      end
      else if (trip_clr && trip_q)
      begin
        trip_q            <= 1'b0;
        cause_q           <= 4'h0;
        o_trip_data_valid <= 1'b0;
        o_trip_current    <= 16'h0000;
        o_trip_timestamp  <= 32'h0000_0000;
      end
    end
  end

  // a reset press drops the message for one cycle only if the alarm persists
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      msg_q     <= 1'b0;
      dismiss_q <= 1'b0;
    end
    else
    begin
      dismiss_q <= i_alarm_active && (dismiss_q || p_back_alarm);
      msg_q     <= i_alarm_active && !dismiss_q && !p_back_alarm && !p_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_middle_blink <= 1'b0;
      o_trip_led     <= 1'b0;
      o_cause_led    <= 4'h0;
      o_alarm_led    <= 1'b0;
      o_battery_led  <= 1'b0;
      o_edit_value   <= 8'h00;
      o_active_value <= 8'h00;
      o_save_pulse   <= 1'b0;
      o_test_start   <= 1'b0;
      o_meter_reset  <= 1'b0;
    end
    else
    begin
      o_middle_blink <= selectable && blink_on;
      o_trip_led     <= trip_q && flash_on;
      o_cause_led    <= cause_q & {4{flash_on}};
      o_alarm_led    <= i_alarm_active;
      o_battery_led  <= btn_bus.level[BTN_BATTERY] && i_battery_ok;
      o_edit_value   <= cur_val;
      o_active_value <= act_q[func_sel];
      o_save_pulse   <= commit;
      o_test_start   <= test_go;
      o_meter_reset  <= meter_rst;
    end
  end

  assign o_screen       = state_q;
  assign o_item         = idx_q;
  assign o_curve_type   = curve_q;
  assign o_func_index   = func_sel;
  assign o_user_active  = user_q;
  assign o_test_level   = lvl_q;
  assign o_test_prompt  = state_q == ST_TEST && lvl_q != 4'h0;
  assign o_meter_screen = idx_q;
  assign o_alarm_msg    = msg_q;

endmodule : fpm_menu_ctrl
`default_nettype wire

// ===== rtl/fpm_pkg.sv
package fpm_pkg;

  // clock and timing
  localparam int CLK_HZ            = 50_000_000;
  localparam int DEBOUNCE_MS       = 10;
  localparam int DEBOUNCE_CYC      = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int TRIP_FLASH_S      = 4;
  localparam int TRIP_FLASH_CYC    = CLK_HZ * TRIP_FLASH_S;
  localparam int TRIP_FLASH_ON_MS  = 100;
  localparam int TRIP_FLASH_ON_CYC = (CLK_HZ / 1000) * TRIP_FLASH_ON_MS;
  localparam int BLINK_MS          = 1000;
  localparam int BLINK_CYC         = (CLK_HZ / 1000) * BLINK_MS;

  // pushbutton positions on the button vector
  localparam int BTN_CNT       = 9;
  localparam int BTN_VIEW_UP   = 0;
  localparam int BTN_VIEW_DOWN = 1;
  localparam int BTN_BACK      = 2;
  localparam int BTN_CHOOSE    = 3;
  localparam int BTN_RESET     = 4;
  localparam int BTN_EDIT_UP   = 5;
  localparam int BTN_EDIT_DOWN = 6;
  localparam int BTN_SAVE      = 7;
  localparam int BTN_BATTERY   = 8;

  // menu geometry
  localparam logic [3:0] PWR_ALT_CNT   = 4'h4;
  localparam logic [4:0] MAIN_ITEMS    = 5'h03;
  localparam logic [4:0] MAIN_METER    = 5'h00;
  localparam logic [4:0] MAIN_PROGRAM  = 5'h01;
  localparam logic [4:0] MAIN_TEST     = 5'h02;
  localparam logic [4:0] CURVE_TYPES   = 5'h03;
  localparam logic [4:0] METER_MAX     = 5'h16;
  localparam logic [4:0] TRIP_PAGES    = 5'h03;
  localparam int         FUNC_CNT      = 8;
  localparam logic [2:0] FUNC_GND0     = 3'h5;
  localparam logic [2:0] FUNC_NEUTRAL  = 3'h7;
  localparam logic [2:0] FUNC_VIS_3EL  = 3'h6;
  localparam logic [2:0] FUNC_VIS_4EL  = 3'h7;
  localparam logic [7:0] VAL_MAX       = 8'hFF;
  localparam logic [7:0] FACTORY_VAL   = 8'h00;
  localparam logic [1:0] FACTORY_CURVE = 2'h0;
  localparam logic [3:0] TEST_LVL_MAX  = 4'hF;

  typedef enum logic [3:0] {
    ST_BOOT   = 4'h0,
    ST_PWR_A  = 4'h1,
    ST_PWR_B  = 4'h2,
    ST_PROMPT = 4'h3,
    ST_MAIN   = 4'h4,
    ST_CURVE  = 4'h5,
    ST_EDIT   = 4'h6,
    ST_TEST   = 4'h7,
    ST_METER  = 4'h8,
    ST_TRIP   = 4'h9
  } fpm_state_type;

  function automatic logic [4:0] fpm_wrap_inc(input logic [4:0] v, input logic [4:0] cnt);
    return (v >= cnt - 5'h01) ? 5'h00 : v + 5'h01;
  endfunction : fpm_wrap_inc

  function automatic logic [4:0] fpm_wrap_dec(input logic [4:0] v, input logic [4:0] cnt);
    return (v == 5'h00 || v >= cnt) ? cnt - 5'h01 : v - 5'h01;
  endfunction : fpm_wrap_dec

  // list position to function slot; three-element units skip the ground slots
  function automatic logic [2:0] fpm_func_map(input logic [2:0] pos, input logic four_el);
    return (!four_el && pos == FUNC_GND0) ? FUNC_NEUTRAL : pos;
  endfunction : fpm_func_map

endpackage : fpm_pkg

// ===== rtl/fpm_btn_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fpm_btn_if #(parameter int N = 9);
  logic [N-1:0] press;
  logic [N-1:0] level;
  modport src (output press, output level);
  modport dst (input press, input level);
endinterface : fpm_btn_if
`default_nettype wire

// ===== rtl/fpm_debounce.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_debounce
  import fpm_pkg::*;
#(
  parameter int N   = BTN_CNT,
  parameter int CNT = DEBOUNCE_CYC
)
(
  // clock and reset
  input  wire logic      i_ref_clk,
  input  wire logic      i_rst,
  // raw buttons, high while pressed
  input  wire logic [N-1:0] i_raw,
  // clean levels and press pulses
  fpm_btn_if.src         btn
);
  localparam int CW = (CNT < 2) ? 1 : $clog2(CNT + 1);

  if (CNT < 1 || N < 1)
  begin : g_bad_param
    $error("fpm_debounce: bad parameters");
  end

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_btn
      logic [CW-1:0] cnt_q;
      logic          stable_q;
      logic          press_q;
      wire           differ  = i_raw[g] != stable_q;
      wire           settled = cnt_q == CW'(CNT - 1);
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          cnt_q    <= '0;
          stable_q <= 1'b0;
          press_q  <= 1'b0;
        end
        else
        begin
          cnt_q    <= (differ && !settled) ? cnt_q + CW'(1) : '0;
          stable_q <= (differ && settled) ? i_raw[g] : stable_q;
          press_q  <= differ && settled && i_raw[g];
        end
      end
      assign btn.press[g] = press_q;
      assign btn.level[g] = stable_q;
    end
  endgenerate
endmodule : fpm_debounce
`default_nettype wire

// ===== rtl/fpm_ticker.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_ticker
  import fpm_pkg::*;
#(
  parameter int PERIOD = BLINK_CYC,
  parameter int ON     = BLINK_CYC / 2
)
(
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // one pulse per period, and a phase high for the first ON cycles
  output logic      o_tick,
  output logic      o_on
);
  localparam int CW = $clog2(PERIOD);

  if (PERIOD < 2 || ON < 1 || ON > PERIOD)
  begin : g_bad_param
    $error("fpm_ticker: bad parameters");
  end

  logic [CW-1:0] cnt_q;
  wire           wrap = cnt_q == CW'(PERIOD - 1);

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
      o_on   <= 1'b0;
    end
    else
    begin
      cnt_q  <= wrap ? '0 : cnt_q + CW'(1);
      o_tick <= wrap;
      o_on   <= wrap || (cnt_q < CW'(ON - 1));
    end
  end
endmodule : fpm_ticker
`default_nettype wire

// ===== test/fpm_menu_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_menu_ctrl_properties
  import fpm_pkg::*;
(
  // clock and reset
  input wire logic          i_ref_clk,
  input wire logic          i_rst,
  // watched inputs
  input wire logic          i_alarm_active,
  input wire logic          i_battery_ok,
  input wire logic          i_trip_event,
  input wire logic [15:0]   i_trip_current,
  // watched outputs
  input wire fpm_state_type o_screen,
  input wire logic [4:0]    o_item,
  input wire logic          o_middle_blink,
  input wire logic          o_user_active,
  input wire logic          o_save_pulse,
  input wire logic [3:0]    o_test_level,
  input wire logic          o_test_start,
  input wire logic          o_meter_reset,
  input wire logic          o_trip_data_valid,
  input wire logic [15:0]   o_trip_current,
  input wire logic          o_log_write,
  input wire logic          o_alarm_led,
  input wire logic          o_battery_led
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_trip_capture;
    i_trip_event |=> o_screen == ST_TRIP && o_item == 5'h00 && o_trip_data_valid
      && o_log_write && o_trip_current == $past(i_trip_current);
  endproperty
  a_trip_capture: assert property (p_trip_capture) else $error("trip not captured");
  property p_log_once;
    o_log_write |=> !o_log_write;
  endproperty
  a_log_once: assert property (p_log_once) else $error("log write too long");
  property p_save;
    o_save_pulse |-> o_user_active ##1 !o_save_pulse;
  endproperty
  a_save: assert property (p_save) else $error("save did not activate user set");
  // blink register may trail the screen by one cycle
  property p_blink;
    o_middle_blink |-> o_screen inside {ST_MAIN, ST_CURVE, ST_PROMPT}
      || $past(o_screen) inside {ST_MAIN, ST_CURVE, ST_PROMPT};
  endproperty
  a_blink: assert property (p_blink) else $error("blink on plain screen");
  property p_alarm_led;
    i_alarm_active |=> o_alarm_led;
  endproperty
  a_alarm_led: assert property (p_alarm_led) else $error("alarm led dark");
  property p_battery;
    o_battery_led |-> $past(i_battery_ok);
  endproperty
  a_battery: assert property (p_battery) else $error("battery led without good battery");
  property p_test_level;
    o_test_level != $past(o_test_level) |-> $past(o_screen) == ST_TEST;
  endproperty
  a_test_level: assert property (p_test_level) else $error("test level moved");
  property p_test_start;
    o_test_start |-> $past(o_screen) == ST_TEST;
  endproperty
  a_test_start: assert property (p_test_start) else $error("test launched outside");
  property p_meter_reset;
    o_meter_reset |-> $past(o_screen) == ST_METER;
  endproperty
  a_meter_reset: assert property (p_meter_reset) else $error("meter reset outside");
endmodule : fpm_menu_ctrl_properties
bind fpm_menu_ctrl fpm_menu_ctrl_properties u_props (.*);
`default_nettype wire

// ===== test/fpm_operator.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_operator
  import fpm_pkg::*;
#(
  parameter int HOLD = 10
)
(
  // clock
  input  wire logic  i_ref_clk,
  // raw pushbuttons
  output logic [8:0] o_buttons
);
  initial o_buttons = 9'h000;
  // held well past the debounce window both ways, so one press is one action
  task automatic press(input int b);
    @(posedge i_ref_clk) #1 o_buttons[b] = 1'b1;
    repeat (HOLD) @(posedge i_ref_clk);
    #1 o_buttons[b] = 1'b0;
    repeat (HOLD) @(posedge i_ref_clk);
    #1;
  endtask : press
  task automatic set_btn(input int b, input logic v);
    @(posedge i_ref_clk) #1 o_buttons[b] = v;
  endtask : set_btn
endmodule : fpm_operator
`default_nettype wire

// ===== test/front_panel_menu_controller_tb.sv
`timescale 1ns/1ns
`default_nettype none
module front_panel_menu_controller_tb;
  import fpm_pkg::*;
  logic          i_ref_clk = 1'b0;
  logic          rst = 1'b1, saved = 1'b0, alarm = 1'b0, batt = 1'b0, trip_ev = 1'b0;
  logic [3:0]    cause = 4'h0;
  logic [15:0]   cur = 16'h0000;
  logic [31:0]   ts = 32'h00000000;
  wire  [8:0]    buttons;
  fpm_state_type screen;
  logic [4:0]    item;
  logic [7:0]    edit_val, active_val;
  logic [3:0]    test_lvl, cause_led;
  logic [15:0]   trip_cur;
  logic [31:0]   trip_ts;
  logic          user_act, valid, trip_led, alarm_led, alarm_msg, batt_led;
  logic          four_el = 1'b0, tprompt, tstart, spulse, mrst;
  logic [4:0]    mscr = 5'h03, meter_scr;
  logic [1:0]    curve;
  logic [2:0]    func_idx;
  logic [11:0]   pulses = 12'h000;
  int            mismatches = 0;
  int            compares = 0;
  always #10 i_ref_clk = ~i_ref_clk;
  // nibbles count save, test start and meter reset pulses
  always @(posedge i_ref_clk)
    if (!rst) pulses <= pulses + {3'h0, spulse, 3'h0, tstart, 3'h0, mrst};
  fpm_operator u_op (.i_ref_clk(i_ref_clk), .o_buttons(buttons));
  fpm_menu_ctrl #(.P_DEBOUNCE_CYC(4), .P_TRIP_FLASH_CYC(40), .P_TRIP_ON_CYC(4),
    .P_BLINK_CYC(8), .P_METER_MAX(5'h16)) DUT (
    .i_ref_clk(i_ref_clk), .i_rst(rst), .i_buttons(buttons), .i_settings_saved(saved),
    .i_four_element(four_el), .i_alarm_active(alarm), .i_battery_ok(batt),
    .i_meter_screens(mscr), .i_trip_event(trip_ev), .i_trip_cause(cause),
    .i_trip_current(cur), .i_trip_timestamp(ts), .o_screen(screen), .o_item(item),
    .o_middle_blink(), .o_curve_type(curve), .o_func_index(func_idx), .o_edit_value(edit_val),
    .o_active_value(active_val), .o_user_active(user_act), .o_save_pulse(spulse),
    .o_test_level(test_lvl), .o_test_prompt(tprompt), .o_test_start(tstart),
    .o_meter_reset(mrst), .o_meter_screen(meter_scr), .o_trip_data_valid(valid),
    .o_trip_current(trip_cur),
    .o_trip_timestamp(trip_ts), .o_log_write(), .o_trip_led(trip_led),
    .o_cause_led(cause_led), .o_alarm_led(alarm_led), .o_alarm_msg(alarm_msg),
    .o_battery_led(batt_led));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset(input logic sv);
    @(posedge i_ref_clk) #1 saved = sv;
    rst = 1'b1;
    repeat (20) @(posedge i_ref_clk);
    #1 rst = 1'b0;
  endtask : do_reset
  task automatic summarize;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    mismatches++;
    summarize;
  end
  initial
  begin
    do_reset(1'b0);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(screen, ST_PROMPT);
    u_op.press(BTN_CHOOSE);
    chk({screen, item}, {ST_CURVE, 5'h00});
    u_op.press(BTN_VIEW_UP);
    u_op.press(BTN_CHOOSE);
    chk({screen, curve}, {ST_EDIT, 2'h1});
    u_op.press(BTN_VIEW_DOWN);
    chk(func_idx, 3'h7);
    four_el = 1'b1;
    #1 chk(func_idx, 3'h5);
    four_el = 1'b0;
    u_op.press(BTN_VIEW_UP);
    chk({item, func_idx}, 8'h00);
    u_op.press(BTN_EDIT_UP);
    chk({edit_val, active_val}, {8'h01, FACTORY_VAL});
    u_op.press(BTN_SAVE);
    chk({user_act, active_val}, 9'h101);
    u_op.press(BTN_BACK);
    u_op.press(BTN_BACK);
    chk({screen, item}, {ST_MAIN, MAIN_PROGRAM});
    u_op.press(BTN_VIEW_DOWN);
    u_op.press(BTN_VIEW_DOWN);
    chk(item, MAIN_TEST);
    u_op.press(BTN_CHOOSE);
    chk(screen, ST_TEST);
    u_op.press(BTN_EDIT_UP);
    chk({test_lvl, tprompt}, 5'h03);
    u_op.press(BTN_SAVE);
    u_op.press(BTN_BACK);
    repeat (3)
      if (item !== MAIN_METER)
        u_op.press(BTN_VIEW_UP);
    u_op.press(BTN_CHOOSE);
    chk(screen, ST_METER);
    u_op.press(BTN_VIEW_DOWN);
    chk(meter_scr, 5'h02);
    mscr = 5'h00;
    u_op.press(BTN_VIEW_DOWN);
    chk(meter_scr, 5'h00);
    u_op.press(BTN_RESET);
    chk(pulses, 12'h111);
    @(posedge i_ref_clk) #1 {cause, cur, ts, trip_ev} = {4'hA, 16'hFFFF, 32'h1234ABCD, 1'b1};
    @(posedge i_ref_clk) #1 trip_ev = 1'b0;
    chk(screen, ST_TRIP);
    chk(trip_cur, 16'hFFFF);
    chk(trip_ts, 32'h1234ABCD);
    repeat (40)
      if (trip_led !== 1'b1)
        @(posedge i_ref_clk) #1;
    chk({trip_led, cause_led}, 5'h1A);
    u_op.press(BTN_VIEW_DOWN);
    chk(item, 5'h01);
    u_op.press(BTN_RESET);
    chk({valid, trip_led, cause_led, screen}, {6'h00, ST_MAIN});
    alarm = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 chk({alarm_led, alarm_msg}, 2'h3);
    u_op.press(BTN_RESET);
    chk({alarm_led, alarm_msg}, 2'h3);
    u_op.press(BTN_BACK);
    chk({alarm_led, alarm_msg, screen}, {2'h2, ST_MAIN});
    alarm = 1'b0;
    batt = 1'b1;
    u_op.set_btn(BTN_BATTERY, 1'b1);
    repeat (10) @(posedge i_ref_clk);
    #1 chk(batt_led, 1'b1);
    batt = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1 chk(batt_led, 1'b0);
    u_op.set_btn(BTN_BATTERY, 1'b0);
    do_reset(1'b1);
    @(posedge i_ref_clk) #1;
    chk({screen, user_act}, {ST_PWR_A, 1'b1});
    repeat (60) @(posedge i_ref_clk);
    #1 chk(screen, ST_MAIN);
    do_reset(1'b0);
    u_op.press(BTN_BACK);
    chk({screen, user_act}, {ST_MAIN, 1'b0});
    summarize;
  end
endmodule : front_panel_menu_controller_tb
`default_nettype wire
